// ---- common/bcfr_pkg.sv ----
// Constants and types for the board communication fault reporter
package bcfr_pkg;

    // ------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MISC = 8'h04;
    localparam logic [7:0] REG_CARD_TOP = 8'h08;
    localparam logic [7:0] REG_CARD_BOT = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_CLR = 8'h14;
    localparam logic [7:0] REG_IRQ_EN = 8'h18;
    localparam logic [7:0] REG_CAT = 8'h1c;
    localparam logic [7:0] REG_HOLD_IDX = 8'h20;
    localparam logic [7:0] REG_HOLD_DATA = 8'h24;
    localparam logic [7:0] REG_AMP_Q = 8'h28;
    localparam logic [7:0] REG_PATH_Q = 8'h2c;
    localparam logic [7:0] REG_CHAR_BASE = 8'h40;
    localparam logic [7:0] REG_CHAR_LAST = 8'h80;

    // ------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_MODEL_LSB = 0;
    localparam int CTRL_DET_BIT = 2;
    localparam int CTRL_COMB_BIT = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [2:0] CAT_RST = 3'h0;

    // ------------------------------------------------------------
    // Board identifiers on the poll result port
    // ------------------------------------------------------------
    localparam logic [6:0] BRD_BP1 = 7'h00;
    localparam logic [6:0] BRD_BP2 = 7'h01;
    localparam logic [6:0] BRD_DET1 = 7'h02;
    localparam logic [6:0] BRD_DET2 = 7'h03;
    localparam logic [6:0] BRD_COMB = 7'h04;
    localparam logic [6:0] BRD_AMP1 = 7'h05;
    localparam int MISC_N = 9;
    localparam int CARD_ID_BIT = 6;
    localparam int CAGE_BIT = 5;

    // ------------------------------------------------------------
    // Held status memory
    // ------------------------------------------------------------
    localparam int HOLD_W = 16;
    localparam int HOLD_AW = 4;

    // ------------------------------------------------------------
    // Interrupt bits
    // ------------------------------------------------------------
    localparam int IRQ_LOST = 0;
    localparam int IRQ_BACK = 1;
    localparam int IRQ_W = 2;

    // ------------------------------------------------------------
    // Status strings
    // ------------------------------------------------------------
    localparam int STR_LEN = 17;
    localparam int CARD_DIGITS = 16;
    localparam logic [7:0] CHR_B = 8'h42;
    localparam logic [7:0] CHR_D = 8'h44;
    localparam logic [7:0] CHR_C = 8'h43;
    localparam logic [7:0] CHR_A = 8'h41;
    localparam logic [7:0] CHR_S = 8'h53;
    localparam logic [7:0] CHR_O = 8'h4f;
    localparam logic [7:0] CHR_K = 8'h4b;
    localparam logic [7:0] CHR_ZERO = 8'h30;
    localparam logic [7:0] CHR_ALPHA = 8'h37;

    typedef enum logic [1:0] {
        MDL_CAGE32,
        MDL_SLOT16,
        MDL_RELAY6,
        MDL_RELAY12
    } bcfr_model_t;

    typedef enum logic [2:0] {
        CAT_BP,
        CAT_DET,
        CAT_COMB,
        CAT_AMP,
        CAT_CARD
    } bcfr_cat_t;

endpackage

// ---- hw/bcfr_hold_mem.sv ----
// Last-known status memory for polled boards
`timescale 1ns/1ps
module bcfr_hold_mem
    import bcfr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Write side
    input wire logic we,
    input wire logic [HOLD_AW-1:0] waddr,
    input wire logic [HOLD_W-1:0] wdata,
    // Read side
    input wire logic [HOLD_AW-1:0] raddr,
    output logic [HOLD_W-1:0] rdata_q
);

    logic [HOLD_W-1:0] mem [2**HOLD_AW];

    // Storage; untouched unless a good poll writes it
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[raddr];
        end
    end

endmodule

// ---- hw/bcfr_top.sv ----
// Board communication fault reporter: flags, strings, registers
//
// Functional notes
// - Backplane code B plus two hex digits; bit0 controller 1, bit1 controller 2.
// - Detector code D, same two-bit layout, only when detection fitted.
// - Combiner shows OK when talking, 01 when silent; absent never flagged.
// - Four amp boards in one digit, bits 0-3; all good shows OK.
// - Amp board n serves amplifiers 8n-7 to 8n.
// - Silent amp board keeps last pass/fail and supply states unchanged.
// - Card string is S plus 16 hex digits, one bit per silent card.
// - Big matrix: upper eight digits bottom cage, slot 32 in MSB.
// - Sixteen-slot matrix uses low four digits, slot 1 highest bit.
// - Six-slot matrix: slots 1-2 bits 5-4, slots 3-6 last digit.
// - All cards good gives an all-zero card string.
// - Twelve-slot listing: slot n sets bit n-1, slots 1-4 lowest digit.
// - Odd slot 2k-1 serves inputs 1-8, even slot 2k inputs 9-16.
// - Silent board keeps reported voltage status at last received values.
`timescale 1ns/1ps
module bcfr_top
    import bcfr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Poll results from the internal bus master
    input wire logic poll_valid,
    input wire logic [6:0] poll_board,
    input wire logic poll_ok,
    input wire logic [HOLD_W-1:0] poll_data,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata_q,
    // Status outputs
    output logic irq_q,
    output logic fault_q
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Upper-case ASCII for one nibble
    function automatic logic [7:0] hex_ascii(input logic [3:0] n);
        if (n < 4'ha) begin
            hex_ascii = CHR_ZERO + {4'h0, n};
        end else begin
            hex_ascii = CHR_ALPHA + {4'h0, n};
        end
    endfunction

    // Reverse the low bits so slot 1 lands in the highest position
    function automatic logic [15:0] rev16(input logic [15:0] v);
        for (int i = 0; i < 16; i++) begin
            rev16[i] = v[15-i];
        end
    endfunction

    // Card word per model; top/bot are indexed by slot-1
    function automatic logic [63:0] card_map(input bcfr_model_t m,
                                             input logic [31:0] top,
                                             input logic [31:0] bot);
        card_map = '0;
        case (m)
            MDL_CAGE32: card_map = {bot, top};
            MDL_SLOT16: card_map[15:0] = rev16(top[15:0]);
            MDL_RELAY6: begin
                for (int i = 0; i < 6; i++) begin
                    card_map[5-i] = top[i];
                end
            end
            MDL_RELAY12: card_map[11:0] = top[11:0];
            default: card_map = '0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Control and configuration registers
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_q;
    logic [2:0] cat_q;
    logic [HOLD_AW-1:0] hold_idx_q;
    logic [4:0] amp_sel_q;
    logic [2:0] path_out_q;
    logic [3:0] path_in_q;
    bcfr_model_t model;
    logic det_fit;
    logic comb_fit;

    assign model = bcfr_model_t'(ctrl_q[CTRL_MODEL_LSB+:2]);
    assign det_fit = ctrl_q[CTRL_DET_BIT];
    assign comb_fit = ctrl_q[CTRL_COMB_BIT];

    // Software-written configuration
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RST;
            cat_q <= CAT_RST;
            hold_idx_q <= '0;
            amp_sel_q <= '0;
            path_out_q <= '0;
            path_in_q <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: ctrl_q <= reg_wdata[CTRL_W-1:0];
                REG_CAT: cat_q <= reg_wdata[2:0];
                REG_HOLD_IDX: hold_idx_q <= reg_wdata[HOLD_AW-1:0];
                REG_AMP_Q: amp_sel_q <= reg_wdata[4:0];
                REG_PATH_Q: begin
                    path_out_q <= reg_wdata[6:4];
                    path_in_q <= reg_wdata[3:0];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Per-board not-communicating flags
    // ------------------------------------------------------------
    logic [MISC_N-1:0] misc_q;
    logic [31:0] card_top_q;
    logic [31:0] card_bot_q;
    logic is_card;
    logic is_misc;
    logic old_flag;

    assign is_card = poll_board[CARD_ID_BIT];
    assign is_misc = !is_card && (poll_board < 7'(MISC_N));

    // Flag held before this poll, for edge events
    always_comb begin
        old_flag = 1'b0;
        if (is_card && poll_board[CAGE_BIT]) begin
            old_flag = card_bot_q[poll_board[4:0]];
        end else if (is_card) begin
            old_flag = card_top_q[poll_board[4:0]];
        end else if (is_misc) begin
            old_flag = misc_q[poll_board[3:0]];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            misc_q <= '0;
            card_top_q <= '0;
            card_bot_q <= '0;
        end else begin
            if (poll_valid && is_misc) begin
                misc_q[poll_board[3:0]] <= !poll_ok;
            end
            if (poll_valid && is_card && poll_board[CAGE_BIT]) begin
                card_bot_q[poll_board[4:0]] <= !poll_ok;
            end
            if (poll_valid && is_card && !poll_board[CAGE_BIT]) begin
                card_top_q[poll_board[4:0]] <= !poll_ok;
            end
            if (!comb_fit) begin
                misc_q[BRD_COMB[3:0]] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Last-known status store
    // ------------------------------------------------------------
    logic hold_we;
    logic [HOLD_W-1:0] hold_rdata;

    assign hold_we = poll_valid && is_misc && poll_ok;

    bcfr_hold_mem u_hold (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .we(hold_we),
        .waddr(poll_board[HOLD_AW-1:0]),
        .wdata(poll_data),
        .raddr(hold_idx_q),
        .rdata_q(hold_rdata)
    );

    // ------------------------------------------------------------
    // Status string assembly
    // ------------------------------------------------------------
    logic [63:0] card_word;
    logic [1:0] bp_bits;
    logic [1:0] det_bits;
    logic [3:0] amp_bits;
    logic [7:0] str [STR_LEN];

    assign card_word = card_map(model, card_top_q, card_bot_q);
    assign bp_bits = misc_q[BRD_BP2[3:0]:BRD_BP1[3:0]];
    assign det_bits = det_fit ? misc_q[BRD_DET2[3:0]:BRD_DET1[3:0]] : 2'b00;
    assign amp_bits = misc_q[BRD_AMP1[3:0]+:4];

    // Selected string; cheap since only one is built at a time
    always_comb begin
        for (int i = 0; i < STR_LEN; i++) begin
            str[i] = 8'h00;
        end
        case (bcfr_cat_t'(cat_q))
            CAT_BP: begin
                str[0] = CHR_B;
                str[1] = CHR_ZERO;
                str[2] = hex_ascii({2'b00, bp_bits});
            end
            CAT_DET: begin
                str[0] = CHR_D;
                str[1] = CHR_ZERO;
                str[2] = hex_ascii({2'b00, det_bits});
            end
            CAT_COMB: begin
                str[0] = CHR_C;
                str[1] = misc_q[BRD_COMB[3:0]] ? CHR_ZERO : CHR_O;
                str[2] = misc_q[BRD_COMB[3:0]] ? hex_ascii(4'h1) : CHR_K;
            end
            // amp digit, OK when all good
            CAT_AMP: begin
                str[0] = CHR_A;
                str[1] = (amp_bits == 4'h0) ? CHR_O : CHR_ZERO;
                str[2] = (amp_bits == 4'h0) ? CHR_K : hex_ascii(amp_bits);
            end
            CAT_CARD: begin
                str[0] = CHR_S;
                for (int d = 0; d < CARD_DIGITS; d++) begin
                    str[d+1] = hex_ascii(card_word[(CARD_DIGITS-1-d)*4+:4]);
                end
            end
            default: ;
        endcase
    end

    // ------------------------------------------------------------
    // Serving-board lookups
    // ------------------------------------------------------------
    logic [1:0] amp_board;
    logic [3:0] path_slot;
    logic path_flag;

    assign amp_board = amp_sel_q[4:3];

    // odd slot low inputs, even slot high inputs
    always_comb begin
        path_slot = {path_out_q, 1'b0} - 4'h1;
        if (path_in_q[3]) begin
            path_slot = {path_out_q, 1'b0};
        end
        path_flag = card_top_q[path_slot - 4'h1];
    end

    // ------------------------------------------------------------
    // Interrupt status, enable and clear
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    // no loss event from an absent combiner
    assign irq_set[IRQ_LOST] = poll_valid && !poll_ok && !old_flag &&
                               (is_card || is_misc) &&
                               !(poll_board == BRD_COMB && !comb_fit);
    assign irq_set[IRQ_BACK] = poll_valid && poll_ok && old_flag;
    assign irq_clr = (reg_wr && reg_addr == REG_IRQ_CLR) ?
                     reg_wdata[IRQ_W-1:0] : '0;

    // Sticky bits; a new event beats a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    // Enable register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_en_q <= '0;
        end else if (reg_wr && reg_addr == REG_IRQ_EN) begin
            irq_en_q <= reg_wdata[IRQ_W-1:0];
        end
    end

    // Level outputs, one cycle behind their sources
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_en_q);
            fault_q <= (|bp_bits) || (|det_bits) || (|amp_bits) ||
                       misc_q[BRD_COMB[3:0]] || (|card_word);
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_d;
    logic [7:0] char_off;

    assign char_off = reg_addr - REG_CHAR_BASE;

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_d = '0;
        case (reg_addr)
            REG_CTRL: rd_d[CTRL_W-1:0] = ctrl_q;
            REG_MISC: rd_d[MISC_N-1:0] = misc_q;
            REG_CARD_TOP: rd_d = card_top_q;
            REG_CARD_BOT: rd_d = card_bot_q;
            REG_IRQ_STAT: rd_d[IRQ_W-1:0] = irq_stat_q;
            REG_IRQ_EN: rd_d[IRQ_W-1:0] = irq_en_q;
            REG_CAT: rd_d[2:0] = cat_q;
            REG_HOLD_IDX: rd_d[HOLD_AW-1:0] = hold_idx_q;
            REG_HOLD_DATA: rd_d[HOLD_W-1:0] = hold_rdata;
            REG_AMP_Q: rd_d[3:0] = {amp_board, 1'b0,
                                   misc_q[BRD_AMP1[3:0] + {2'b00, amp_board}]};
            REG_PATH_Q: rd_d[4:0] = {path_slot, path_flag};
            default: begin
                if (reg_addr >= REG_CHAR_BASE && reg_addr <= REG_CHAR_LAST &&
                    reg_addr[1:0] == 2'b00) begin
                    rd_d[7:0] = str[char_off[6:2]];
                end
            end
        endcase
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata_q <= '0;
        end else begin
            reg_rdata_q <= reg_rd ? rd_d : '0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    flag_set_a: assert property (
        poll_valid && poll_board == BRD_BP1 && !poll_ok |=> misc_q[0])
        else $error("backplane flag not set after failed poll");
    bp_code_a: assert property (
        cat_q == CAT_BP && misc_q[1:0] == 2'b11 |->
        str[0] == CHR_B && str[2] == 8'h33)
        else $error("backplane code wrong");
    comb_ok_a: assert property (
        cat_q == CAT_COMB && !comb_fit && !$past(comb_fit) |->
        str[1] == CHR_O)
        else $error("absent combiner flagged");
    amp_ok_a: assert property (
        cat_q == CAT_AMP && misc_q[8:5] == 4'h0 |-> str[2] == CHR_K)
        else $error("amp all good not OK");
    hold_keep_a: assert property (
        !($past(poll_valid, 2) && $past(poll_ok, 2)) &&
        !$past(sys_rst) && !$past(sys_rst, 2) &&
        $past(hold_idx_q) == $past(hold_idx_q, 2) |-> $stable(hold_rdata))
        else $error("held status changed without a good poll");
    big_cage_a: assert property (
        model == MDL_CAGE32 |-> card_word[63] == card_bot_q[31] &&
        card_word[0] == card_top_q[0])
        else $error("big matrix placement wrong");
    slot16_a: assert property (
        model == MDL_SLOT16 |-> card_word[15] == card_top_q[0] &&
        card_word[63:16] == '0)
        else $error("sixteen slot placement wrong");
    relay6_a: assert property (
        model == MDL_RELAY6 |-> card_word[5] == card_top_q[0] &&
        card_word[0] == card_top_q[5] && card_word[63:6] == '0)
        else $error("six slot placement wrong");
    all_zero_a: assert property (
        card_top_q == '0 && card_bot_q == '0 |-> card_word == '0)
        else $error("card word not zero");
    relay12_a: assert property (
        model == MDL_RELAY12 |-> card_word[11] == card_top_q[11] &&
        card_word[63:12] == '0)
        else $error("twelve slot placement wrong");
    irq_level_a: assert property (
        $rose(irq_stat_q[IRQ_LOST]) && irq_en_q[IRQ_LOST] |-> ##1 irq_q)
        else $error("interrupt not raised");
    read_time_a: assert property (
        reg_rd && reg_addr == REG_CTRL |=>
        reg_rdata_q[CTRL_W-1:0] == $past(ctrl_q))
        else $error("read data late or wrong");

    card_fault_c: cover property (cat_q == CAT_CARD && |card_word);
    amp_fault_c: cover property (cat_q == CAT_AMP && amp_bits == 4'hf);
    recover_c: cover property (irq_set[IRQ_BACK]);
    hold_read_c: cover property (reg_rd && reg_addr == REG_HOLD_DATA);

endmodule

// ---- testbench/bcfr_board_model.sv ----
// Poll result source standing in for the internal bus master
`timescale 1ns/1ps
module bcfr_board_model
    import bcfr_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Poll result port
    output logic poll_valid,
    output logic [6:0] poll_board,
    output logic poll_ok,
    output logic [HOLD_W-1:0] poll_data
);
    // Idle values at time zero
    initial begin
        poll_valid = 1'b0;
        poll_board = 7'h7f;
        poll_ok = 1'b0;
        poll_data = 16'h0000;
    end

    // One result after a gap; fields inverted once released so that
    // nothing downstream can lean on stale payload
    task automatic poll(input logic [6:0] b, input logic ok,
                        input logic [15:0] d, input int gap);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        poll_valid <= 1'b1;
        poll_board <= b;
        poll_ok <= ok;
        poll_data <= d;
        @(posedge core_clk);
        poll_valid <= 1'b0;
        poll_board <= ~b;
        poll_ok <= ~ok;
        poll_data <= ~d;
    endtask
endmodule

// ---- testbench/test_bcfr_top.sv ----
// Self-checking bench for the board communication fault reporter
`timescale 1ns/1ps
module test_bcfr_top
    import bcfr_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and reference state
    // ------------------------------------------------------------
    logic core_clk, sys_rst, poll_valid, poll_ok, reg_wr, reg_rd;
    logic irq_q, fault_q;
    logic [6:0] poll_board;
    logic [15:0] poll_data;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata_q, top, bot;
    logic [8:0] flg, have;
    logic [15:0] held [9];
    logic [1:0] stat, en;
    logic [3:0] ctrl;
    logic [7:0] pfx [5] = '{CHR_B, CHR_D, CHR_C, CHR_A, CHR_S};
    int mismatches, cmp_count, seed;

    bcfr_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .poll_valid(poll_valid), .poll_board(poll_board),
        .poll_ok(poll_ok), .poll_data(poll_data), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .irq_q(irq_q), .fault_q(fault_q));
    bcfr_board_model i_bus (.core_clk(core_clk), .poll_valid(poll_valid),
        .poll_board(poll_board), .poll_ok(poll_ok), .poll_data(poll_data));

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Reference model of the displayed strings
    // ------------------------------------------------------------
    // Card word as shown, per matrix model; bottom cage only on 32 slots
    function automatic logic [63:0] cards();
        logic [63:0] v;
        v = 64'h0;
        if (ctrl[1:0] == 2'd0) return {bot, top};
        for (int s = 1; s <= 16; s++) begin
            if (ctrl[1:0] == 2'd1) v[16-s] = top[s-1];
            else if (ctrl[1:0] == 2'd2 && s <= 6) v[6-s] = top[s-1];
            else if (ctrl[1:0] == 2'd3 && s <= 12) v[s-1] = top[s-1];
        end
        return v;
    endfunction

    function automatic logic [7:0] ch(int cat, int i);
        logic [63:0] v;
        logic [3:0] d;
        int n;
        case (cat)
            0: v = {62'h0, flg[1:0]};
            1: v = ctrl[2] ? {62'h0, flg[3:2]} : 64'h0;
            2: v = {63'h0, ctrl[3] & flg[4]};
            3: v = {60'h0, flg[8:5]};
            default: v = cards();
        endcase
        n = (cat == 4) ? 16 : 2;
        if (i == 0) return pfx[cat];
        if ((cat == 2 || cat == 3) && v == 64'h0) begin
            return (i == 1) ? CHR_O : ((i == 2) ? CHR_K : 8'h00);
        end
        if (i > n) return 8'h00;
        d = v[4*(n-i) +: 4];
        return (d > 4'd9) ? CHR_ALPHA + d : CHR_ZERO + d;
    endfunction

    // ------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk_word(reg_rdata_q, exp);
    endtask

    // Random poll, mostly valid ids, model updated alongside
    task automatic do_poll();
        logic [6:0] b;
        logic [31:0] r;
        logic nf, prev;
        r = $random(seed);
        b = r[6:0];
        if (b[6:5] == 2'b01) b = b % 7'd9;
        nf = ~r[8];
        prev = nf;
        if (b[6] && b[5]) prev = bot[b[4:0]];
        if (b[6] && b[5]) bot[b[4:0]] = nf;
        if (b[6] && !b[5]) prev = top[b[4:0]];
        if (b[6] && !b[5]) top[b[4:0]] = nf;
        if (b == BRD_COMB && !ctrl[3]) nf = 1'b0;
        if (b < 7'd9) prev = flg[b];
        if (b < 7'd9) flg[b] = nf;
        if (b < 7'd9 && r[8]) held[b] = r[31:16];
        if (b < 7'd9 && r[8]) have[b] = 1'b1;
        if (prev != nf) stat[nf ? IRQ_LOST : IRQ_BACK] = 1'b1;
        i_bus.poll(b, r[8], r[31:16], r[10:9]);
    endtask

    task automatic end_sim();
        if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [3:0] cfgs [5];
        logic [31:0] r;
        logic [4:0] slot;
        cfgs = '{4'hf, 4'h5, 4'h6, 4'h3, 4'h0};
        seed = 32'hf23c;
        {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 42'h0};
        {flg, have, top, bot, stat, ctrl} = 0;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdc(REG_CTRL, {28'h0, CTRL_RST}); // reset value
        rdc(REG_MISC, 32'h0);
        rdc(8'h3c, 32'h0);
        rdc(REG_IRQ_CLR, 32'h0);
        foreach (cfgs[c]) begin
            ctrl = cfgs[c];
            wr(REG_CTRL, {28'h0, ctrl});
            if (!ctrl[3]) flg[4] = 1'b0;
            r = $random(seed);
            en = r[1:0];
            wr(REG_IRQ_EN, {30'h0, en});
            repeat (40) do_poll();
            wr(REG_MISC, 32'hffffffff);
            rdc(REG_CTRL, {28'h0, ctrl});
            rdc(REG_MISC, {23'h0, flg});
            rdc(REG_CARD_TOP, top);
            rdc(REG_CARD_BOT, bot);
            rdc(REG_IRQ_STAT, {30'h0, stat});
            chk_bit(irq_q, |(stat & en));
            chk_bit(fault_q, |{flg[8:4], flg[3:2] & {2{ctrl[2]}},
                flg[1:0]} | |cards());
            for (int k = 0; k < 5; k++) begin
                wr(REG_CAT, k);
                for (int i = 0; i < STR_LEN; i++) begin
                    rdc(REG_CHAR_BASE + 8'(4 * i), {24'h0, ch(k, i)}); // 4 12
                end
            end
            for (int id = 0; id < 9; id++) begin
                wr(REG_HOLD_IDX, id);
                repeat (2) @(posedge core_clk);
                if (have[id]) rdc(REG_HOLD_DATA, {16'h0, held[id]});
            end
            r = $random(seed);
            wr(REG_AMP_Q, {27'h0, r[4:0]});
            rdc(REG_AMP_Q, {28'h0, r[4:3], 1'b0, flg[5 + r[4:3]]});
            slot = 5'(2 * (1 + r[15:8] % 6) - (r[19] ? 0 : 1));
            wr(REG_PATH_Q, {25'h0, 3'((slot + 1) / 2), r[19:16]});
            rdc(REG_PATH_Q, {27'h0, slot[3:0], top[slot - 1]});
            wr(REG_IRQ_CLR, {30'h0, r[21:20]});
            stat = stat & ~r[21:20];
        end
        end_sim();
    end
endmodule
